// ---- rtl/uaf_flow.sv ----
`include "uaf_cfg.svh"
`default_nettype none

// Behaviour
// RQ1 - Ring indicator rising edge raises status interrupt
// RQ2 - Control bit 1 drives request-to-send low
// RQ3 - Request-to-send held high after reset
// RQ4 - Loopback feeds transmit serial into receiver
// RQ5 - Receive-ready low at trigger or timeout
// RQ6 - Receive-ready high when empty or errored
// RQ7 - Transmit-ready low when free space reaches trigger
// RQ8 - Transmit-ready high when transmit buffer full
// RQ9 - Auto-CTS checks clear-to-send before each byte
// RQ10 - Auto-RTS drops at trigger 1, 4, 8
// RQ11 - Auto-RTS returns once receive queue emptied
// RQ12 - Trigger 14 drops on 16th character's bit
// RQ13 - Trigger 14 returns with one free location
// RQ14 - Receiver still accepts one byte after drop
// RQ15 - Remote drops clear-to-send before last stop middle
// RQ16 - No clear-to-send interrupts under autoflow
// RQ17 - Without auto-CTS transmit ignores clear-to-send
// RQ18 - Autoflow bit 5 plus bit 1 enable both
// RQ19 - Software clears bit 1 for auto-CTS only
// RQ20 - Clear-to-send is active low
// RQ21 - Receive trigger selects 1, 4, 8 or 14
module uaf_flow
  import uaf_pkg::*;
#(
  parameter int TX_WIDTH = `UAF_TX_WIDTH,
  parameter int TX_DEPTH = `UAF_TX_DEPTH,
  parameter int RX_LVL_W = `UAF_RX_LVL_W,
  parameter int TXC_W    = $clog2(TX_DEPTH + 1)
) (
  input  wire logic                clock,
  input  wire logic                resetn,

  input  wire logic                modem_rts_bit,
  input  wire logic                autoflow_enable_bit,
  input  wire logic                loopback_bit,
  input  wire logic                ms_int_enable,
  input  wire uaf_trig_sel_t       rx_trig_sel,
  input  wire logic [TXC_W-1:0]    tx_trig_level,

  input  wire logic                ring_indicator_n,
  input  wire logic                cts_n,
  input  wire logic                ms_read,

  input  wire logic                serial_in,
  input  wire logic                tx_serial,
  output logic                     serial_out,
  output logic                     receiver_in,

  input  wire logic [RX_LVL_W-1:0] rx_level,
  input  wire logic                rx_first_data_bit,
  input  wire logic                rx_timeout_int,
  input  wire logic                rx_fifo_error,

  input  wire logic                tx_in_valid,
  output logic                     tx_in_ready,
  input  wire logic [TX_WIDTH-1:0] tx_in_data,
  input  wire logic                tx_start_ready,
  output logic                     tx_byte_valid,
  output logic      [TX_WIDTH-1:0] tx_byte,

  output logic                     rts_n,
  output logic                     rx_ready_n,
  output logic                     tx_ready_n,
  output logic                     ms_irq,
  output logic                     ring_edge_flag,
  output logic                     cts_delta_flag,
  output logic                     auto_rts_active,
  output logic                     auto_cts_active
);

  // Trigger decode shared by flow control and receive-ready
  function automatic logic [RX_LVL_W-1:0] trig_bytes(input uaf_trig_sel_t sel);
    logic [RX_LVL_W-1:0] bytes;
    bytes = RX_LVL_W'(`UAF_TRIG_BYTES_1);
    unique case (sel)
      `UAF_SEL_TRIG_1:  bytes = RX_LVL_W'(`UAF_TRIG_BYTES_1);
      `UAF_SEL_TRIG_4:  bytes = RX_LVL_W'(`UAF_TRIG_BYTES_4);
      `UAF_SEL_TRIG_8:  bytes = RX_LVL_W'(`UAF_TRIG_BYTES_8);
      `UAF_SEL_TRIG_14: bytes = RX_LVL_W'(`UAF_TRIG_BYTES_14);
    endcase
    return bytes;
  endfunction

  // Mode decode
  wire autoflow_on;
  wire rts_auto;
  wire cts_auto;
  wire trig_is_14;

  assign autoflow_on = autoflow_enable_bit;
  assign cts_auto    = autoflow_enable_bit; // RQ18
  assign rts_auto    = autoflow_enable_bit && modem_rts_bit; // RQ18
  assign trig_is_14  = (rx_trig_sel == `UAF_SEL_TRIG_14);

  // Receive level compares
  wire [RX_LVL_W-1:0] trig_level;
  wire                rx_at_trig;
  wire                rx_empty;
  wire                rx_holds_15;
  wire                rx_full;
  wire                rx_has_space;

  assign trig_level   = trig_bytes(rx_trig_sel); // RQ21
  assign rx_at_trig   = (rx_level >= trig_level);
  assign rx_empty     = (rx_level == RX_LVL_W'(`UAF_LEVEL_EMPTY));
  assign rx_holds_15  = (rx_level >= RX_LVL_W'(`UAF_LEVEL_15));
  assign rx_full      = (rx_level >= RX_LVL_W'(`UAF_LEVEL_FULL));
  assign rx_has_space = !rx_full;

  // Auto request-to-send state
  uaf_rts_state_t rts_state;
  uaf_rts_state_t next_rts_state;
  logic           seen_full;
  logic           next_seen_full;

  always_comb begin
    next_rts_state = rts_state;
    next_seen_full = seen_full;
    unique case (rts_state)
      UAF_RTS_GRANT: begin
        next_seen_full = `UAF_FLAG_CLEAR;
        if (trig_is_14) begin
          if (rx_first_data_bit && rx_holds_15) begin
            next_rts_state = UAF_RTS_STOP14; // RQ12
          end
        end else if (rx_at_trig) begin
          next_rts_state = UAF_RTS_STOP; // RQ10
        end
      end
      UAF_RTS_STOP: begin
        if (trig_is_14) begin
          next_rts_state = UAF_RTS_STOP14;
        end else if (rx_empty) begin
          next_rts_state = UAF_RTS_GRANT; // RQ11
        end
      end
      UAF_RTS_STOP14: begin
        if (rx_full) begin
          next_seen_full = 1'h1;
        end
        if (!trig_is_14) begin
          next_rts_state = UAF_RTS_STOP;
        // Below 15 also grants; no deadlock without a 16th
        end else if ((seen_full && rx_has_space) || !rx_holds_15) begin
          next_rts_state = UAF_RTS_GRANT; // RQ13
        end
      end
      default: begin
        next_rts_state = UAF_RTS_GRANT;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rts_state <= UAF_RTS_GRANT;
      seen_full <= `UAF_FLAG_CLEAR;
    end else begin
      rts_state <= next_rts_state;
      seen_full <= next_seen_full;
    end
  end

  // Request-to-send pin level
  wire rts_grant;
  wire next_rts_n;

  assign rts_grant  = !rts_auto || (next_rts_state == UAF_RTS_GRANT);
  assign next_rts_n = !(modem_rts_bit && rts_grant); // RQ2

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rts_n <= `UAF_PIN_INACTIVE; // RQ3
    end else begin
      rts_n <= next_rts_n;
    end
  end

  // Receive-ready pin
  wire rxr_release;
  wire rxr_assert;

  assign rxr_release = rx_empty || rx_fifo_error; // RQ6
  assign rxr_assert  = rx_at_trig || rx_timeout_int; // RQ5

  // Empty or error beats trigger
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_ready_n <= `UAF_PIN_INACTIVE;
    end else if (rxr_release) begin
      rx_ready_n <= `UAF_PIN_INACTIVE;
    end else if (rxr_assert) begin
      rx_ready_n <= 1'h0;
    end
  end

  // Transmit buffer
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [TX_WIDTH-1:0] fifo_out_data;
  logic [TXC_W-1:0]    fifo_count;

  uaf_fifo #(
    .WIDTH (TX_WIDTH),
    .DEPTH (TX_DEPTH),
    .CW    (TXC_W)
  ) u_tx_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (tx_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  // Transmit-ready pin
  wire [TXC_W-1:0] tx_free;
  wire             tx_full;
  wire             tx_room;

  assign tx_free = TXC_W'(TX_DEPTH) - fifo_count;
  assign tx_full = (fifo_count == TXC_W'(TX_DEPTH));
  assign tx_room = (tx_free >= tx_trig_level);

  // Full forces the inactive level
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_ready_n <= `UAF_PIN_INACTIVE;
    end else if (tx_full) begin
      tx_ready_n <= `UAF_PIN_INACTIVE; // RQ8
    end else begin
      tx_ready_n <= !tx_room; // RQ7
    end
  end

  // Byte launch gated by clear-to-send
  wire cts_active;
  wire cts_ok;
  wire launch;

  assign cts_active     = !cts_n; // RQ20
  assign cts_ok         = !cts_auto || cts_active; // RQ9 RQ17
  assign launch         = fifo_out_valid && tx_start_ready && cts_ok && !tx_byte_valid; // RQ9
  assign fifo_out_ready = launch;

  // Launch pulse blocks the next cycle's launch
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_byte_valid <= `UAF_FLAG_CLEAR;
      tx_byte       <= '0;
    end else begin
      tx_byte_valid <= launch;
      if (launch) begin
        tx_byte <= fifo_out_data;
      end
    end
  end

  // Loopback routing; receiver never blocked by flow state
  wire next_receiver_in;
  wire next_serial_out;

  assign next_receiver_in = loopback_bit ? tx_serial : serial_in; // RQ4 RQ14
  assign next_serial_out  = loopback_bit ? `UAF_LINE_IDLE : tx_serial;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      receiver_in <= `UAF_LINE_IDLE;
      serial_out  <= `UAF_LINE_IDLE;
    end else begin
      receiver_in <= next_receiver_in;
      serial_out  <= next_serial_out;
    end
  end

  // Modem status events
  logic ring_prev;
  logic cts_prev;

  wire ring_rise;
  wire cts_change;
  wire cts_event;

  assign ring_rise  = !ring_prev && ring_indicator_n; // RQ1
  assign cts_change = (cts_prev != cts_n);
  assign cts_event  = cts_change && !autoflow_on; // RQ16

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ring_prev <= `UAF_PIN_INACTIVE;
      // CTS may already be active in reset; no false change after
      cts_prev  <= cts_n;
    end else begin
      ring_prev <= ring_indicator_n;
      cts_prev  <= cts_n;
    end
  end

  // Sticky flags; a new event beats the read clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ring_edge_flag <= `UAF_FLAG_CLEAR;
      cts_delta_flag <= `UAF_FLAG_CLEAR;
    end else begin
      ring_edge_flag <= ring_rise || (ring_edge_flag && !ms_read); // RQ1
      cts_delta_flag <= cts_event || (cts_delta_flag && !ms_read); // RQ16
    end
  end

  wire next_ms_irq;

  assign next_ms_irq = ms_int_enable && (ring_edge_flag || cts_delta_flag); // RQ1

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ms_irq <= `UAF_FLAG_CLEAR;
    end else begin
      ms_irq <= next_ms_irq;
    end
  end

  // Mode indicators
  always_ff @(posedge clock) begin
    if (!resetn) begin
      auto_rts_active <= `UAF_FLAG_CLEAR;
      auto_cts_active <= `UAF_FLAG_CLEAR;
    end else begin
      auto_rts_active <= rts_auto;
      auto_cts_active <= cts_auto;
    end
  end

endmodule

`default_nettype wire

// ---- inc/uaf_cfg.svh ----
`ifndef UAF_CFG_SVH
`define UAF_CFG_SVH

`define UAF_TX_WIDTH      8
`define UAF_TX_DEPTH      8
`define UAF_RX_DEPTH      16
`define UAF_RX_LVL_W      5

`define UAF_SEL_TRIG_1    2'h0
`define UAF_SEL_TRIG_4    2'h1
`define UAF_SEL_TRIG_8    2'h2
`define UAF_SEL_TRIG_14   2'h3

`define UAF_TRIG_BYTES_1  5'h01
`define UAF_TRIG_BYTES_4  5'h04
`define UAF_TRIG_BYTES_8  5'h08
`define UAF_TRIG_BYTES_14 5'h0e

`define UAF_LEVEL_EMPTY   5'h00
`define UAF_LEVEL_15      5'h0f
`define UAF_LEVEL_FULL    5'h10

`define UAF_PIN_INACTIVE  1'h1
`define UAF_LINE_IDLE     1'h1
`define UAF_FLAG_CLEAR    1'h0

`endif

// ---- inc/uaf_pkg.sv ----
`default_nettype none

package uaf_pkg;

  typedef enum logic [2:0] {
    UAF_RTS_GRANT  = 3'h1,
    UAF_RTS_STOP   = 3'h2,
    UAF_RTS_STOP14 = 3'h4
  } uaf_rts_state_t;

  typedef logic [1:0] uaf_trig_sel_t;

endpackage

`default_nettype wire

// ---- rtl/uaf_fifo.sv ----
`include "uaf_cfg.svh"
`default_nettype none

module uaf_fifo #(
  parameter int WIDTH = `UAF_TX_WIDTH,
  parameter int DEPTH = `UAF_TX_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1),
  parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CW-1:0]    count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  wire [AW-1:0] wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
  wire [AW-1:0] rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_inc;
      end
      if (pop) begin
        rd_ptr <= rd_inc;
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end

endmodule

`default_nettype wire

// ---- sim/uaf_line_model.sv ----
`default_nettype none

module uaf_line_model (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic tx_byte_valid,
  input  wire logic hold_off,
  output logic      cts_n,
  output logic      tx_start_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] busy;
  // Remote holds off before the next byte starts
  assign cts_n = hold_off;
  assign tx_start_ready = (busy == 3'h0);
  // Transmitter busy for a few cycles per byte
  always_ff @(posedge clock) begin
    if (!resetn)
      busy <= 3'h0;
    else if (tx_byte_valid)
      busy <= 3'h4;
    else if (busy != 3'h0)
      busy <= busy - 3'h1;
  end
endmodule

`default_nettype wire

// ---- sim/uaf_flow_chk.sv ----
`include "uaf_cfg.svh"
`default_nettype none

module uaf_flow_chk
  import uaf_pkg::*;
#(
  parameter int RX_LVL_W = `UAF_RX_LVL_W
) (
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic                modem_rts_bit,
  input wire logic                autoflow_enable_bit,
  input wire uaf_trig_sel_t       rx_trig_sel,
  input wire logic                ring_indicator_n,
  input wire logic                cts_n,
  input wire logic [RX_LVL_W-1:0] rx_level,
  input wire logic                rx_fifo_error,
  input wire logic                tx_in_ready,
  input wire logic                tx_byte_valid,
  input wire logic                rts_n,
  input wire logic                rx_ready_n,
  input wire logic                tx_ready_n,
  input wire logic                ring_edge_flag,
  input wire logic                cts_delta_flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic [4:0] trig;
  logic       rts_auto;
  assign trig = (rx_trig_sel == `UAF_SEL_TRIG_1) ? `UAF_TRIG_BYTES_1 :
                (rx_trig_sel == `UAF_SEL_TRIG_4) ? `UAF_TRIG_BYTES_4 :
                (rx_trig_sel == `UAF_SEL_TRIG_8) ? `UAF_TRIG_BYTES_8 : `UAF_TRIG_BYTES_14;
  assign rts_auto = autoflow_enable_bit && modem_rts_bit;
  chk_reset_idle: assert property (disable iff (1'b0) !resetn |=> rts_n && rx_ready_n)
    else $error("pins not idle in reset");
  chk_rts_manual: assert property (!autoflow_enable_bit |=> rts_n == !$past(modem_rts_bit))
    else $error("rts not from control bit");
  chk_ring_flag: assert property ($rose(ring_indicator_n) |-> ##[1:2] ring_edge_flag)
    else $error("ring edge missed");
  chk_txrdy_full: assert property (!tx_in_ready |=> tx_ready_n)
    else $error("tx ready low while full");
  chk_rxrdy_clear: assert property (rx_level == 5'h00 || rx_fifo_error |=> rx_ready_n)
    else $error("rx ready not released");
  chk_rxrdy_set: assert property (rx_level >= trig && !rx_fifo_error |=> !rx_ready_n)
    else $error("rx ready not set");
  chk_cts_gate: assert property (autoflow_enable_bit && cts_n |=> !tx_byte_valid)
    else $error("byte launched while held off");
  chk_rts_stop: assert property (rts_auto && rx_trig_sel != `UAF_SEL_TRIG_14 && rx_level >= trig
    |-> ##[1:2] rts_n)
    else $error("rts not stopped at trigger");
  chk_cts_quiet: assert property (autoflow_enable_bit && !cts_delta_flag |=> !cts_delta_flag)
    else $error("cts change flagged under autoflow");
  cov_launch: cover property (tx_byte_valid);
  cov_stop: cover property (rts_auto && rts_n);
  cov_ring: cover property (ring_edge_flag);
endmodule

bind uaf_flow uaf_flow_chk #(.RX_LVL_W(RX_LVL_W)) i_uaf_flow_chk (
  .clock               (clock),
  .resetn              (resetn),
  .modem_rts_bit       (modem_rts_bit),
  .autoflow_enable_bit (autoflow_enable_bit),
  .rx_trig_sel         (rx_trig_sel),
  .ring_indicator_n    (ring_indicator_n),
  .cts_n               (cts_n),
  .rx_level            (rx_level),
  .rx_fifo_error       (rx_fifo_error),
  .tx_in_ready         (tx_in_ready),
  .tx_byte_valid       (tx_byte_valid),
  .rts_n               (rts_n),
  .rx_ready_n          (rx_ready_n),
  .tx_ready_n          (tx_ready_n),
  .ring_edge_flag      (ring_edge_flag),
  .cts_delta_flag      (cts_delta_flag)
);

`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none

module tb_top
  import uaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, modem_rts_bit, autoflow_enable_bit, loopback_bit, ms_int_enable, ms_read;
  logic ring_indicator_n, cts_n, serial_in, tx_serial, serial_out, receiver_in, hold_off;
  logic rx_first_data_bit, rx_timeout_int, rx_fifo_error, tx_in_valid, tx_in_ready, tx_start_ready;
  logic tx_byte_valid, rts_n, rx_ready_n, tx_ready_n, ms_irq, ring_edge_flag, cts_delta_flag;
  logic auto_rts_active, auto_cts_active;
  uaf_trig_sel_t rx_trig_sel;
  logic [3:0] tx_trig_level;
  logic [4:0] rx_level;
  logic [7:0] tx_in_data, tx_byte, got[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int trig[4] = '{1, 4, 8, 14};
  uaf_flow i_uaf_flow (
    .clock               (clock),
    .resetn              (resetn),
    .modem_rts_bit       (modem_rts_bit),
    .autoflow_enable_bit (autoflow_enable_bit),
    .loopback_bit        (loopback_bit),
    .ms_int_enable       (ms_int_enable),
    .rx_trig_sel         (rx_trig_sel),
    .tx_trig_level       (tx_trig_level),
    .ring_indicator_n    (ring_indicator_n),
    .cts_n               (cts_n),
    .ms_read             (ms_read),
    .serial_in           (serial_in),
    .tx_serial           (tx_serial),
    .serial_out          (serial_out),
    .receiver_in         (receiver_in),
    .rx_level            (rx_level),
    .rx_first_data_bit   (rx_first_data_bit),
    .rx_timeout_int      (rx_timeout_int),
    .rx_fifo_error       (rx_fifo_error),
    .tx_in_valid         (tx_in_valid),
    .tx_in_ready         (tx_in_ready),
    .tx_in_data          (tx_in_data),
    .tx_start_ready      (tx_start_ready),
    .tx_byte_valid       (tx_byte_valid),
    .tx_byte             (tx_byte),
    .rts_n               (rts_n),
    .rx_ready_n          (rx_ready_n),
    .tx_ready_n          (tx_ready_n),
    .ms_irq              (ms_irq),
    .ring_edge_flag      (ring_edge_flag),
    .cts_delta_flag      (cts_delta_flag),
    .auto_rts_active     (auto_rts_active),
    .auto_cts_active     (auto_cts_active)
  );
  uaf_line_model i_uaf_line_model (
    .clock          (clock),
    .resetn         (resetn),
    .tx_byte_valid  (tx_byte_valid),
    .hold_off       (hold_off),
    .cts_n          (cts_n),
    .tx_start_ready (tx_start_ready)
  );
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (tx_byte_valid === 1'b1)
      got.push_back(tx_byte);
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic fill(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      tx_in_valid <= 1'b1;
      tx_in_data <= base + 8'(i);
    end
    @(posedge clock);
    tx_in_valid <= 1'b0;
    step(1);
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    n_mismatch++;
    summarize();
  end
  initial begin
    {resetn, modem_rts_bit, autoflow_enable_bit, loopback_bit, ms_int_enable, ms_read, hold_off} = '0;
    {rx_first_data_bit, rx_timeout_int, rx_fifo_error, tx_in_valid, tx_in_data, tx_serial} = '0;
    {ring_indicator_n, serial_in} = 2'h3;
    rx_trig_sel = 2'h0;
    tx_trig_level = 4'h4;
    rx_level = 5'h00;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    step(1);
    check("rts", rts_n, 1);
    @(posedge clock);
    modem_rts_bit <= 1'b1;
    loopback_bit <= 1'b1;
    step(2);
    check("rts", rts_n, 0);
    check("rx_in", receiver_in, 0);
    check("tx_out", serial_out, 1);
    @(posedge clock);
    loopback_bit <= 1'b0;
    ms_int_enable <= 1'b1;
    ring_indicator_n <= 1'b0;
    step(2);
    check("rx_in", receiver_in, 1);
    check("tx_out", serial_out, 0);
    check("irq", ms_irq, 0);
    @(posedge clock);
    ring_indicator_n <= 1'b1;
    step(3);
    check("irq", ms_irq, 1);
    @(posedge clock);
    ms_read <= 1'b1;
    autoflow_enable_bit <= 1'b1;
    @(posedge clock);
    ms_read <= 1'b0;
    hold_off <= 1'b1;
    fill(4, 8'h10);
    check("txrdy", tx_ready_n, 0);
    fill(1, 8'h14);
    check("txrdy", tx_ready_n, 1);
    fill(3, 8'h15);
    check("in_rdy", tx_in_ready, 0);
    check("txrdy", tx_ready_n, 1);
    check("sent", 8'(got.size()), 0);
    check("cts_flag", cts_delta_flag, 0);
    check("ring", ring_edge_flag, 0);
    @(posedge clock);
    hold_off <= 1'b0;
    step(60);
    check("sent", 8'(got.size()), 8);
    foreach (got[i]) check("byte", got[i], 8'h10 + 8'(i));
    check("txrdy", tx_ready_n, 0);
    @(posedge clock);
    autoflow_enable_bit <= 1'b0;
    hold_off <= 1'b1;
    got.delete();
    fill(2, 8'h40);
    step(20);
    check("sent", 8'(got.size()), 2);
    check("cts_flag", cts_delta_flag, 1);
    @(posedge clock);
    autoflow_enable_bit <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      @(posedge clock);
      rx_trig_sel <= uaf_trig_sel_t'(t);
      rx_level <= 5'(trig[t] - 1);
      step(2);
      check("rts", rts_n, 0);
      @(posedge clock);
      rx_level <= 5'(trig[t]);
      step(2);
      check("rts", rts_n, t < 3);
      check("rxrdy", rx_ready_n, 0);
      @(posedge clock);
      rx_level <= 5'(trig[t] + 1);
      rx_first_data_bit <= (t == 3);
      @(posedge clock);
      rx_first_data_bit <= 1'b0;
      step(2);
      check("rts", rts_n, 1);
      @(posedge clock);
      rx_level <= (t == 3) ? 5'h10 : 5'h01;
      @(posedge clock);
      rx_level <= (t == 3) ? 5'h0f : 5'h01;
      step(2);
      check("rts", rts_n, t < 3);
      @(posedge clock);
      rx_level <= 5'h00;
      step(2);
      check("rts", rts_n, 0);
      check("rxrdy", rx_ready_n, 1);
    end
    @(posedge clock);
    rx_level <= 5'h02;
    rx_timeout_int <= 1'b1;
    step(2);
    check("rxrdy", rx_ready_n, 0);
    @(posedge clock);
    rx_level <= 5'h0e;
    rx_timeout_int <= 1'b0;
    rx_fifo_error <= 1'b1;
    modem_rts_bit <= 1'b0;
    step(2);
    check("rxrdy", rx_ready_n, 1);
    check("rts", rts_n, 1);
    check("auto", {auto_rts_active, auto_cts_active}, 8'h01);
    summarize();
  end
endmodule

`default_nettype wire
